// File: design/pwfe_core.sv
// Control sequencing: fetch a two-instruction program word, run upper then lower.
// Assumes storage units give one done pulse per start, reads and writes alike.
`default_nettype none

// Overview of operation
// - Two storage units split odd/even addresses
// - Instruction: opcode, designator, base address
// - Upper 24 bits upper instruction
// - Six index registers modify addresses
// - Program address fetches word into control
// - Upper first; lower unless jump taken
// - Lower half moved up before execution
// - Base to aux, index to buffer, add
// - Low bit picks unit, rest addresses
// - Fetch: upper 14 bits to unit
// - Add: read operand, add to accumulator
// - Enter index via aux and buffer
// - Each unit read through own rank
// - Write data held in register
// - Accumulator adds operand, shifts, combined shift
// - Auxiliary register ANDs operand, shifts
// - Buffer carries index transfers
// - Designator zero unmodified, seven indirect
module pwfe_core (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [47:0] even_rdata,
  input  wire logic        even_done,
  input  wire logic [47:0] odd_rdata,
  input  wire logic        odd_done,
  output logic      [13:0] even_storage_addr_reg,
  output logic      [13:0] odd_storage_addr_reg,
  output logic             even_start,
  output logic             odd_start,
  output logic             even_write,
  output logic             odd_write,
  output logic      [47:0] write_data_reg,
  output logic      [47:0] accumulator,
  output logic      [47:0] aux_arith_reg,
  output logic      [14:0] program_addr,
  output logic      [47:0] program_control_reg,
  output logic             instr_done
);

  pwfe_pkg::pwfe_state_e state_r;
  pwfe_pkg::pwfe_state_e state_nxt;

  logic [14:0] aux_program_control_reg;
  logic [14:0] addr_buf_r;
  logic [47:0] operand_r;
  logic        lower_pending_r;
  logic        indirect_done_r;
  logic [14:0] index_r [0:7];

  logic [5:0]  op;
  logic [2:0]  desig;
  logic [14:0] base;
  logic        needs_read;
  logic        is_write;
  logic        indirect_ok;
  logic        jump_taken;
  logic        mem_req;
  logic        mem_write;
  logic [14:0] mem_addr;
  logic [47:0] rd_word;
  logic        rd_done;
  logic [6:0]  shift_cnt;
  logic [95:0] aq_shifted;

  assign op    = program_control_reg[pwfe_pkg::OP_HI:pwfe_pkg::OP_LO];
  assign desig = program_control_reg[pwfe_pkg::DES_HI:pwfe_pkg::DES_LO];
  assign base  = program_control_reg[pwfe_pkg::BASE_HI:pwfe_pkg::BASE_LO];

  assign shift_cnt  = aux_program_control_reg[pwfe_pkg::SHIFT_W-1:0];
  assign aq_shifted = $signed({accumulator, aux_arith_reg}) >>> shift_cnt;

  assign needs_read = (op == pwfe_pkg::OP_ADD) || (op == pwfe_pkg::OP_LOAD_A)
                   || (op == pwfe_pkg::OP_LOAD_Q) || (op == pwfe_pkg::OP_AND_Q);
  assign is_write   = (op == pwfe_pkg::OP_STORE_A);

  always_comb begin
    jump_taken = 1'b0;
    if (op == pwfe_pkg::OP_JUMP) begin
      jump_taken = 1'b1;
    end else if (op == pwfe_pkg::OP_JUMP_A) begin
      unique case (desig)
        pwfe_pkg::J_ZERO:    jump_taken = (accumulator == pwfe_pkg::WORD_RST);
        pwfe_pkg::J_NONZERO: jump_taken = (accumulator != pwfe_pkg::WORD_RST);
        pwfe_pkg::J_POS:     jump_taken = !accumulator[pwfe_pkg::WORD_W-1];
        pwfe_pkg::J_NEG:     jump_taken = accumulator[pwfe_pkg::WORD_W-1];
        default:             jump_taken = 1'b0;
      endcase
    end
  end

  // Storage request: fetch uses the program address, operands the aux register
  assign mem_req   = (state_r == pwfe_pkg::PWFE_FETCH_REQ)
                  || (state_r == pwfe_pkg::PWFE_OPER_REQ);
  assign mem_write = (state_r == pwfe_pkg::PWFE_OPER_REQ) && is_write && indirect_ok;
  assign mem_addr  = (state_r == pwfe_pkg::PWFE_FETCH_REQ) ? program_addr
                                                           : aux_program_control_reg;

  // True once indirection, if any, has been resolved; a jump condition never indirects
  assign indirect_ok = (desig != pwfe_pkg::DES_INDIRECT) || indirect_done_r
                    || (op == pwfe_pkg::OP_JUMP_A);

  pwfe_storage_sel u_sel (
    .core_clk              (core_clk),
    .rst                   (rst),
    .req                   (mem_req),
    .req_write             (mem_write),
    .req_addr              (mem_addr),
    .even_rdata            (even_rdata),
    .even_done             (even_done),
    .odd_rdata             (odd_rdata),
    .odd_done              (odd_done),
    .even_storage_addr_reg (even_storage_addr_reg),
    .odd_storage_addr_reg  (odd_storage_addr_reg),
    .even_start            (even_start),
    .odd_start             (odd_start),
    .even_write            (even_write),
    .odd_write             (odd_write),
    .rd_word               (rd_word),
    .rd_done               (rd_done)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pwfe_pkg::PWFE_FETCH_REQ:  state_nxt = pwfe_pkg::PWFE_FETCH_WAIT;
      pwfe_pkg::PWFE_FETCH_WAIT: begin
        if (rd_done) begin
          state_nxt = pwfe_pkg::PWFE_DECODE;
        end
      end
      pwfe_pkg::PWFE_DECODE:     state_nxt = pwfe_pkg::PWFE_ADDR_MOD;
      pwfe_pkg::PWFE_ADDR_MOD: begin
        if (!indirect_ok || needs_read || is_write) begin
          state_nxt = pwfe_pkg::PWFE_OPER_REQ;
        end else begin
          state_nxt = pwfe_pkg::PWFE_EXEC;
        end
      end
      pwfe_pkg::PWFE_OPER_REQ:   state_nxt = pwfe_pkg::PWFE_OPER_WAIT;
      pwfe_pkg::PWFE_OPER_WAIT: begin
        if (rd_done && !indirect_ok) begin
          state_nxt = pwfe_pkg::PWFE_ADDR_MOD;
        end else if (rd_done) begin
          state_nxt = pwfe_pkg::PWFE_EXEC;
        end
      end
      pwfe_pkg::PWFE_EXEC: begin
        state_nxt = jump_taken ? pwfe_pkg::PWFE_FETCH_REQ : pwfe_pkg::PWFE_NEXT;
      end
      pwfe_pkg::PWFE_NEXT: begin
        state_nxt = lower_pending_r ? pwfe_pkg::PWFE_DECODE : pwfe_pkg::PWFE_FETCH_REQ;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= pwfe_pkg::PWFE_FETCH_REQ;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      program_control_reg <= pwfe_pkg::WORD_RST;
      lower_pending_r     <= 1'b0;
    end else if (state_r == pwfe_pkg::PWFE_FETCH_WAIT && rd_done) begin
      program_control_reg <= rd_word;
      lower_pending_r     <= 1'b1;
    end else if (state_r == pwfe_pkg::PWFE_NEXT && lower_pending_r) begin
      program_control_reg <= {program_control_reg[pwfe_pkg::LOW_HI:0],
                              pwfe_pkg::WORD_RST[pwfe_pkg::LOW_HI:0]};
      lower_pending_r     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      program_addr <= pwfe_pkg::ADDR_RST;
    end else if (state_r == pwfe_pkg::PWFE_EXEC && jump_taken) begin
      program_addr <= aux_program_control_reg;
    end else if (state_r == pwfe_pkg::PWFE_NEXT && !lower_pending_r) begin
      program_addr <= program_addr + pwfe_pkg::ADDR_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aux_program_control_reg <= pwfe_pkg::ADDR_RST;
    end else if (state_r == pwfe_pkg::PWFE_DECODE) begin
      aux_program_control_reg <= base;
    end else if (state_r == pwfe_pkg::PWFE_ADDR_MOD && op != pwfe_pkg::OP_ENT_IDX) begin
      aux_program_control_reg <= aux_program_control_reg + addr_buf_r;
    end else if (state_r == pwfe_pkg::PWFE_OPER_WAIT && rd_done && !indirect_ok) begin
      aux_program_control_reg <= rd_word[pwfe_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_buf_r <= pwfe_pkg::ADDR_RST;
    end else if (state_r == pwfe_pkg::PWFE_DECODE) begin
      // Jump condition field is not an index designator
      addr_buf_r <= (op == pwfe_pkg::OP_ENT_IDX || op == pwfe_pkg::OP_JUMP_A)
                    ? pwfe_pkg::ADDR_RST : index_r[desig];
    end else if (state_r == pwfe_pkg::PWFE_ADDR_MOD && op == pwfe_pkg::OP_ENT_IDX) begin
      addr_buf_r <= aux_program_control_reg;
    end else if (state_r == pwfe_pkg::PWFE_OPER_WAIT && rd_done) begin
      addr_buf_r <= pwfe_pkg::ADDR_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      indirect_done_r <= 1'b0;
    end else if (state_r == pwfe_pkg::PWFE_DECODE) begin
      indirect_done_r <= 1'b0;
    end else if (state_r == pwfe_pkg::PWFE_OPER_WAIT && rd_done) begin
      indirect_done_r <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_index
      if (g >= pwfe_pkg::DES_IDX_LO && g <= pwfe_pkg::DES_IDX_HI) begin : g_reg
        always_ff @(posedge core_clk) begin
          if (rst) begin
            index_r[g] <= pwfe_pkg::ADDR_RST;
          end else if (state_r == pwfe_pkg::PWFE_EXEC && op == pwfe_pkg::OP_ENT_IDX
                       && desig == 3'(g)) begin
            index_r[g] <= addr_buf_r;
          end
        end
      end else begin : g_none
        assign index_r[g] = pwfe_pkg::ADDR_RST;
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      operand_r <= pwfe_pkg::WORD_RST;
    end else if (state_r == pwfe_pkg::PWFE_OPER_WAIT && rd_done && indirect_ok) begin
      operand_r <= rd_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_data_reg <= pwfe_pkg::WORD_RST;
    end else if (state_r == pwfe_pkg::PWFE_ADDR_MOD && is_write) begin
      write_data_reg <= accumulator;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      accumulator <= pwfe_pkg::WORD_RST;
    end else if (state_r == pwfe_pkg::PWFE_EXEC) begin
      unique case (op)
        pwfe_pkg::OP_ADD:      accumulator <= accumulator + operand_r;
        pwfe_pkg::OP_LOAD_A:   accumulator <= operand_r;
        pwfe_pkg::OP_SHIFT_A:  accumulator <= $signed(accumulator) >>> shift_cnt;
        pwfe_pkg::OP_SHIFT_AQ: accumulator <= aq_shifted[95:48];
        default:               accumulator <= accumulator;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aux_arith_reg <= pwfe_pkg::WORD_RST;
    end else if (state_r == pwfe_pkg::PWFE_EXEC) begin
      unique case (op)
        pwfe_pkg::OP_AND_Q:    aux_arith_reg <= aux_arith_reg & operand_r;
        pwfe_pkg::OP_LOAD_Q:   aux_arith_reg <= operand_r;
        pwfe_pkg::OP_SHIFT_AQ: aux_arith_reg <= aq_shifted[47:0];
        default:               aux_arith_reg <= aux_arith_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= (state_r == pwfe_pkg::PWFE_EXEC);
    end
  end

endmodule : pwfe_core

`default_nettype wire

// File: design/pwfe_pkg.sv
// Shared constants for the program word fetch and execute block.
// Assumes two external storage units that answer a start with a done pulse.
`default_nettype none

package pwfe_pkg;

  localparam int WORD_W  = 48;
  localparam int INSTR_W = 24;
  localparam int ADDR_W  = 15;
  localparam int UNIT_W  = 14;
  localparam int DES_W   = 3;
  localparam int OP_W    = 6;
  localparam int SHIFT_W = 7;

  // Field positions within the upper half of the program control register; LOW_HI tops the lower half
  localparam int OP_HI   = 47;
  localparam int OP_LO   = 42;
  localparam int DES_HI  = 41;
  localparam int DES_LO  = 39;
  localparam int BASE_HI = 38;
  localparam int BASE_LO = 24;
  localparam int LOW_HI  = 23;

  // Index designators
  localparam logic [2:0] DES_NONE     = 3'h0;
  localparam logic [2:0] DES_IDX_LO   = 3'h1;
  localparam logic [2:0] DES_IDX_HI   = 3'h6;
  localparam logic [2:0] DES_INDIRECT = 3'h7;

  // Jump conditions on the accumulator
  localparam logic [2:0] J_ZERO    = 3'h0;
  localparam logic [2:0] J_NONZERO = 3'h1;
  localparam logic [2:0] J_POS     = 3'h2;
  localparam logic [2:0] J_NEG     = 3'h3;

  // Operation codes handled by this block
  localparam logic [5:0] OP_SHIFT_A  = 6'h01;
  localparam logic [5:0] OP_SHIFT_AQ = 6'h03;
  localparam logic [5:0] OP_LOAD_A   = 6'h0a;
  localparam logic [5:0] OP_ADD      = 6'h0c;
  localparam logic [5:0] OP_LOAD_Q   = 6'h0e;
  localparam logic [5:0] OP_AND_Q    = 6'h0f;
  localparam logic [5:0] OP_STORE_A  = 6'h10;
  localparam logic [5:0] OP_JUMP_A   = 6'h12;
  localparam logic [5:0] OP_ENT_IDX  = 6'h28;
  localparam logic [5:0] OP_JUMP     = 6'h3d;

  localparam logic [47:0] WORD_RST = 48'h0;
  localparam logic [14:0] ADDR_RST = 15'h0;
  localparam logic [14:0] ADDR_ONE = 15'h1;

  typedef enum logic [2:0] {
    PWFE_FETCH_REQ  = 3'h0,
    PWFE_FETCH_WAIT = 3'h1,
    PWFE_DECODE     = 3'h3,
    PWFE_ADDR_MOD   = 3'h2,
    PWFE_OPER_REQ   = 3'h6,
    PWFE_OPER_WAIT  = 3'h7,
    PWFE_EXEC       = 3'h5,
    PWFE_NEXT       = 3'h4
  } pwfe_state_e;

endpackage : pwfe_pkg

`default_nettype wire

// File: design/pwfe_storage_sel.sv
// Storage unit steering: picks the even or odd unit by the address low bit.
// Assumes each unit holds its read word valid while its done pulse is high.
`default_nettype none

module pwfe_storage_sel (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [14:0] req_addr,
  input  wire logic [47:0] even_rdata,
  input  wire logic        even_done,
  input  wire logic [47:0] odd_rdata,
  input  wire logic        odd_done,
  output logic      [13:0] even_storage_addr_reg,
  output logic      [13:0] odd_storage_addr_reg,
  output logic             even_start,
  output logic             odd_start,
  output logic             even_write,
  output logic             odd_write,
  output logic      [47:0] rd_word,
  output logic             rd_done
);

  logic        odd_sel;
  logic [47:0] even_read_rank;
  logic [47:0] odd_read_rank;

  assign odd_sel = req_addr[0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      even_storage_addr_reg <= 14'h0;
      odd_storage_addr_reg  <= 14'h0;
    end else if (req && !odd_sel) begin
      even_storage_addr_reg <= req_addr[pwfe_pkg::ADDR_W-1:1];
    end else if (req && odd_sel) begin
      odd_storage_addr_reg <= req_addr[pwfe_pkg::ADDR_W-1:1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      even_start <= 1'b0;
      odd_start  <= 1'b0;
      even_write <= 1'b0;
      odd_write  <= 1'b0;
    end else begin
      even_start <= req && !odd_sel;
      odd_start  <= req && odd_sel;
      even_write <= req && !odd_sel && req_write;
      odd_write  <= req && odd_sel && req_write;
    end
  end

  assign even_read_rank = even_rdata;
  assign odd_read_rank  = odd_rdata;
  assign rd_word = odd_done ? odd_read_rank : even_read_rank;
  assign rd_done = even_done || odd_done;

endmodule : pwfe_storage_sel

`default_nettype wire

// File: sim/pwfe_core_properties.sv
// Concurrent checks on the fetch and execute core ports.
// Assumes binding to pwfe_core; one clock, synchronous active-high reset.
`default_nettype none

module pwfe_core_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [47:0] even_rdata,
  input wire logic        even_done,
  input wire logic [47:0] odd_rdata,
  input wire logic        odd_done,
  input wire logic [13:0] even_storage_addr_reg,
  input wire logic [13:0] odd_storage_addr_reg,
  input wire logic        even_start,
  input wire logic        odd_start,
  input wire logic        even_write,
  input wire logic        odd_write,
  input wire logic [47:0] write_data_reg,
  input wire logic [47:0] accumulator,
  input wire logic [47:0] aux_arith_reg,
  input wire logic [14:0] program_addr,
  input wire logic [47:0] program_control_reg,
  input wire logic        instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [47:0] moved = {program_control_reg[23:0], 24'h0};
  wire logic        any_start = even_start | odd_start;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_one_unit: assert property (!(even_start && odd_start))
    else $error("both storage units started");
  a_fetch_first: assert property ($fell(rst) |-> ##[1:2]
    even_start && even_storage_addr_reg == 14'h0)
    else $error("first fetch not at address zero");
  a_start_pulse: assert property (any_start |=> !any_start)
    else $error("start longer than one cycle");
  a_write_data: assert property ((even_write || odd_write) |->
    any_start && write_data_reg == accumulator)
    else $error("write without start or data mismatch");
  a_addr_hold: assert property (!any_start |->
    $stable(even_storage_addr_reg) && $stable(odd_storage_addr_reg))
    else $error("storage address changed without start");
  a_word_load: assert property ($changed(program_control_reg) |->
    ($past(even_done) && program_control_reg == $past(even_rdata))
    || ($past(odd_done) && program_control_reg == $past(odd_rdata))
    || program_control_reg == $past(moved))
    else $error("control register loaded from wrong source");
  a_acc_done: assert property ($changed(accumulator) |-> ##[0:1] instr_done)
    else $error("accumulator changed outside execution");
  a_next_fetch: assert property ($changed(program_addr) |-> ##[1:6]
    any_start && odd_start == program_addr[0]
    && (odd_start ? odd_storage_addr_reg : even_storage_addr_reg) == program_addr[14:1])
    else $error("fetch does not follow program address");
  a_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("instruction done longer than one cycle");
endmodule : pwfe_core_properties

bind pwfe_core pwfe_core_properties u_props (
  .core_clk(core_clk), .rst(rst), .even_rdata(even_rdata), .even_done(even_done),
  .odd_rdata(odd_rdata), .odd_done(odd_done), .even_storage_addr_reg(even_storage_addr_reg),
  .odd_storage_addr_reg(odd_storage_addr_reg), .even_start(even_start), .odd_start(odd_start),
  .even_write(even_write), .odd_write(odd_write), .write_data_reg(write_data_reg),
  .accumulator(accumulator), .aux_arith_reg(aux_arith_reg), .program_addr(program_addr),
  .program_control_reg(program_control_reg), .instr_done(instr_done)
);

`default_nettype wire

// File: sim/pwfe_storage_model.sv
// Behavioural pair of interleaved storage units, 64 words in all.
// Assumes one outstanding reference; the bench sets latency every cycle.
`default_nettype none

module pwfe_storage_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  lat,
  input  wire logic        even_start,
  input  wire logic        odd_start,
  input  wire logic        even_write,
  input  wire logic        odd_write,
  input  wire logic [13:0] even_storage_addr_reg,
  input  wire logic [13:0] odd_storage_addr_reg,
  input  wire logic [47:0] write_data_reg,
  output logic      [47:0] even_rdata,
  output logic             even_done,
  output logic      [47:0] odd_rdata,
  output logic             odd_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [47:0] mem [0:63];
  logic [47:0] rdata_r = 48'h0;
  logic [47:0] wd_r;
  logic [5:0]  idx_r = 6'h0;
  logic [1:0]  cnt_r;
  logic        busy_r, wr_r;
  logic        done_r = 1'b0;

  // own read path, write data sampled
  always @(posedge core_clk) begin
    done_r <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
    end else if (busy_r && cnt_r == 2'h0) begin
      busy_r  <= 1'b0;
      done_r  <= 1'b1;
      rdata_r <= mem[idx_r];
      if (wr_r) begin
        mem[idx_r] <= wd_r;
      end
    end else if (busy_r) begin
      cnt_r <= cnt_r - 2'h1;
    end else if (even_start || odd_start) begin
      busy_r <= 1'b1;
      cnt_r  <= lat;
      wr_r   <= odd_start ? odd_write : even_write;
      idx_r  <= odd_start ? {odd_storage_addr_reg[4:0], 1'b1} : {even_storage_addr_reg[4:0], 1'b0};
      wd_r   <= write_data_reg;
    end
  end

  // Idle or unselected unit shows the inverted last word
  assign #1 even_done  = done_r & ~idx_r[0];
  assign #1 odd_done   = done_r & idx_r[0];
  assign #1 even_rdata = (done_r & ~idx_r[0]) ? rdata_r : ~rdata_r;
  assign #1 odd_rdata  = (done_r & idx_r[0]) ? rdata_r : ~rdata_r;
endmodule : pwfe_storage_model

`default_nettype wire

// File: sim/tb_program_word_fetch_execute.sv
// Self-checking bench: a small program runs four times, one per jump condition.
// Assumes the storage model answers every start; expectations come from a model here.
`default_nettype none

module tb_program_word_fetch_execute;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NINS = 14;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  lat = 2'h0;
  logic [47:0] even_rdata, odd_rdata, write_data_reg, accumulator, aux_arith_reg;
  logic [47:0] program_control_reg;
  logic        even_done, odd_done, even_start, odd_start, even_write, odd_write, instr_done;
  logic [13:0] even_storage_addr_reg, odd_storage_addr_reg;
  logic [14:0] program_addr;
  logic [15:0] seed = 16'h15;
  logic [47:0] rm [0:63];
  logic [14:0] bx [0:7];
  logic [63:0] q_ref[$];
  logic [63:0] r_m;
  logic [47:0] q_acc[$];
  logic [47:0] q_aux[$];
  logic [63:0] q_pc[$];
  wire logic [14:0] start_addr = {odd_start ? odd_storage_addr_reg : even_storage_addr_reg,
                                  odd_start};
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          ndone = 0;
  bit          chk_on = 1'b0;

  pwfe_core u_dut (.*);
  pwfe_storage_model u_mem (.*);

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  function void step();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
  endfunction : step

  function automatic logic [23:0] iw(logic [5:0] op, logic [2:0] b, logic [14:0] m);
    return {op, b, m};
  endfunction : iw

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Instruction-level model: storage references and register results in order
  task automatic ref_run(input int n);
    logic [47:0] a, q, w;
    logic [95:0] aq;
    logic [23:0] ins;
    logic [14:0] p, ea;
    logic [5:0]  op;
    logic [2:0]  b;
    bit          half, taken;
    a = '0;
    q = '0;
    p = '0;
    half = 1'b0;
    for (int i = 0; i < 8; i++) bx[i] = '0;
    for (int k = 0; k < n; k++) begin
      if (!half) begin
        w = rm[p[5:0]];
        q_ref.push_back({1'b0, p, 48'h0});
      end
      ins = half ? w[23:0] : w[47:24];
      op = ins[23:18];
      b = ins[17:15];
      ea = ins[14:0];
      taken = 1'b0;
      if (b == pwfe_pkg::DES_INDIRECT && op != pwfe_pkg::OP_JUMP_A) begin
        q_ref.push_back({1'b0, ea, 48'h0});
        ea = rm[ea[5:0]][14:0];
      end else if (b != pwfe_pkg::DES_NONE && op != pwfe_pkg::OP_JUMP_A) begin
        ea = ea + bx[b];
      end
      if (op inside {pwfe_pkg::OP_LOAD_A, pwfe_pkg::OP_ADD, pwfe_pkg::OP_LOAD_Q,
                     pwfe_pkg::OP_AND_Q, pwfe_pkg::OP_STORE_A}) begin
        q_ref.push_back({op == pwfe_pkg::OP_STORE_A, ea, a});
      end
      case (op)
        pwfe_pkg::OP_LOAD_A:   a = rm[ea[5:0]];
        pwfe_pkg::OP_ADD:      a = a + rm[ea[5:0]];
        pwfe_pkg::OP_LOAD_Q:   q = rm[ea[5:0]];
        pwfe_pkg::OP_AND_Q:    q = q & rm[ea[5:0]];
        pwfe_pkg::OP_STORE_A:  rm[ea[5:0]] = a;
        pwfe_pkg::OP_SHIFT_A:  a = $signed(a) >>> ea[6:0];
        pwfe_pkg::OP_SHIFT_AQ: begin
          aq = $signed({a, q}) >>> ea[6:0];
          {a, q} = aq;
        end
        pwfe_pkg::OP_JUMP_A:   taken = (b == 3'h0 && a == 0) || (b == 3'h1 && a != 0) ||
                                       (b == 3'h2 && !a[47]) || (b == 3'h3 && a[47]);
        pwfe_pkg::OP_ENT_IDX:  bx[b] = ins[14:0];
        pwfe_pkg::OP_JUMP:     taken = 1'b1;
        default: ;
      endcase
      q_acc.push_back(a);
      q_aux.push_back(q);
      // Program address and control word as they stand when the instruction completes
      q_pc.push_back({1'b0, taken ? ea : p, half ? {w[23:0], 24'h0} : w});
      if (taken) begin
        p = ea;
        half = 1'b0;
      end else if (half) begin
        p = p + 15'h1;
        half = 1'b0;
      end else begin
        half = 1'b1;
      end
    end
  endtask : ref_run

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    #1 step();
    lat = seed[1:0];
    if (cyc == 6000) begin
      err_total++;
      results();
    end
  end

  always @(negedge core_clk) begin
    if (chk_on && (even_start | odd_start) === 1'b1 && q_ref.size() > 0) begin
      r_m = q_ref.pop_front();
      chk({49'h0, start_addr}, {49'h0, r_m[62:48]});
      chk({63'h0, even_write | odd_write}, {63'h0, r_m[63]});
      if (r_m[63]) chk({16'h0, write_data_reg}, {16'h0, r_m[47:0]});
    end
    if (chk_on && instr_done === 1'b1 && q_acc.size() > 0) begin
      chk({16'h0, accumulator}, {16'h0, q_acc.pop_front()});
      chk({16'h0, aux_arith_reg}, {16'h0, q_aux.pop_front()});
      chk({1'b0, program_addr, program_control_reg}, q_pc.pop_front());
      ndone++;
    end
  end

  initial begin
    for (int t = 0; t < 4; t++) begin
      #1 rst = 1'b1;
      chk_on = 1'b0;
      for (int i = 0; i < 64; i++) begin
        step();
        rm[i] = {seed, seed ^ 16'h5a5a, ~seed};
      end
      rm[0] = {iw(pwfe_pkg::OP_ENT_IDX, 3'h6, 15'h3), iw(pwfe_pkg::OP_LOAD_A, 3'h0, 15'h14)};
      rm[1] = {iw(pwfe_pkg::OP_ADD, 3'h6, 15'h12), iw(pwfe_pkg::OP_LOAD_Q, 3'h0, 15'h16)};
      rm[2] = {iw(pwfe_pkg::OP_AND_Q, 3'h0, 15'h17), iw(pwfe_pkg::OP_STORE_A, 3'h0, 15'h1e)};
      rm[3] = {iw(pwfe_pkg::OP_JUMP_A, t[2:0], 15'h6), iw(pwfe_pkg::OP_LOAD_A, 3'h0, 15'h1e)};
      rm[4] = {iw(pwfe_pkg::OP_JUMP, 3'h0, 15'h6), iw(pwfe_pkg::OP_JUMP, 3'h0, 15'h6)};
      rm[6] = {iw(pwfe_pkg::OP_SHIFT_A, 3'h0, 15'h2), iw(pwfe_pkg::OP_SHIFT_AQ, 3'h0, 15'h4)};
      rm[7] = {iw(pwfe_pkg::OP_ADD, 3'h7, 15'h19), iw(pwfe_pkg::OP_JUMP, 3'h0, 15'h0)};
      rm[25][14:0] = 15'h15;
      for (int i = 0; i < 64; i++) u_mem.mem[i] = rm[i];
      ref_run(NINS);
      repeat (5) @(posedge core_clk);
      #1 rst = 1'b0;
      chk_on = 1'b1;
      ndone = 0;
      for (int c = 0; c < 3000 && ndone < NINS; c++) @(posedge core_clk);
      chk({32'h0, q_ref.size()}, 64'h0);
      chk({32'h0, ndone}, {32'h0, NINS});
      $display("test %0d ended after %0d instructions", t, ndone);
      q_ref.delete();
      q_acc.delete();
      q_aux.delete();
      q_pc.delete();
    end
    results();
  end
endmodule : tb_program_word_fetch_execute

`default_nettype wire
